// ===== hdl/adc_ctl_regs.svh
`ifndef ADC_CTL_REGS_SVH
`define ADC_CTL_REGS_SVH

// Register byte offsets
`define OFS_IEN_LOW   8'h00
`define OFS_IEN_HIGH  8'h04
`define OFS_CSS_LOW   8'h08
`define OFS_CSS_HIGH  8'h0c
`define OFS_RDY_LOW   8'h10
`define OFS_RDY_HIGH  8'h14
`define OFS_INT_STS   8'h18
`define OFS_INT_MASK  8'h1c
`define OFS_SCAN_CTL  8'h20

// Implemented-bit masks
`define MASK_LOW      32'h0fff_ffff
`define MASK_IEN_HIGH 32'h003f_e3fe
`define MASK_CSS_HIGH 32'h0037_e3fe
`define MASK_INT      2'h3
`define RST_WORD      32'h0000_0000

// Channel layout
`define LOW_BITS      28
`define HIGH_BASE     32
`define LAST_CH       6'h35
`define CLASS3_FIRST  6'h06
`define CLASS3_LAST   6'h1b
`define INTERNAL_FIRST 6'h32
`define SHARED_CONV   3'h7

// Field positions
`define EVT_CONV      0
`define EVT_SCAN      1
`define SCAN_GO       0
`define SCAN_CH_LSB   8
`define SCAN_CH_MSB   13

`endif

// ===== hdl/adc_ctl_pkg.sv
package adc_ctl_pkg;
    typedef logic [53:0] chan_vec_t;
    typedef logic [5:0]  chan_idx_t;

    typedef enum logic { SEQ_IDLE, SEQ_WAIT } seq_state_e;

    typedef struct packed {
        seq_state_e st;
        chan_vec_t  snap;
        chan_idx_t  chan;
        logic       conv_req;
        logic       busy;
        logic       done;
        logic       class3;
        logic [2:0] conv_id;
        logic       internal;
    } seq_state_s;

    typedef struct packed {
        logic [31:0] ien_lo;
        logic [31:0] ien_hi;
        logic [31:0] css_lo;
        logic [31:0] css_hi;
        chan_vec_t   rdy;
        logic [1:0]  int_sts;
        logic [1:0]  int_mask;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        adc_irq;
        logic        irq;
        logic        start;
    } top_state_s;
endpackage

// ===== hdl/scan_if.sv
interface scan_if;
    import adc_ctl_pkg::*;
    chan_vec_t  sel;
    logic       start;
    chan_vec_t  result_ready;
    logic       busy;
    logic       done;
    logic       conv_req;
    chan_idx_t  chan;
    logic       class3;
    logic [2:0] conv_id;
    logic       internal;

    modport ctrl (output sel, start, result_ready,
                  input busy, done, conv_req, chan, class3, conv_id, internal);
    modport seq  (input sel, start, result_ready,
                  output busy, done, conv_req, chan, class3, conv_id, internal);
endinterface

// ===== hdl/scan_sequencer.sv
`include "adc_ctl_regs.svh"

module scan_sequencer
    import adc_ctl_pkg::*;
(
    input  wire logic pclk,    // Bus clock
    input  wire logic presetn, // Async reset, low
    scan_if.seq       sif      // Scan control link
);
    seq_state_s q;
    seq_state_s d;

    // Lowest selected channel at or above from; bit 6 flags a hit
    function automatic logic [6:0] find_from(chan_vec_t sel, chan_idx_t from);
        logic [6:0] r;
        r = 7'h00;
        for (int i = 53; i >= 0; i--) begin
            if (sel[i] && (6'(i) >= from)) begin
                r = {1'b1, 6'(i)};
            end
        end
        return r;
    endfunction

    function automatic seq_state_s issue(seq_state_s s, chan_idx_t ch);
        seq_state_s t;
        t          = s;
        t.chan     = ch;
        t.conv_req = 1'b1;
        t.class3   = (ch >= `CLASS3_FIRST) && (ch <= `CLASS3_LAST);
        t.conv_id  = t.class3 ? `SHARED_CONV : ch[2:0];
        t.internal = (ch >= `INTERNAL_FIRST);
        return t;
    endfunction

    logic [6:0] hit;

    always_comb begin
        d        = q;
        d.conv_req = 1'b0;
        d.done   = 1'b0;
        hit      = 7'h00;
        case (q.st)
            SEQ_IDLE: begin
                // Starts with nothing selected are dropped
                if (sif.start && (sif.sel != '0)) begin
                    hit    = find_from(sif.sel, 6'h00);
                    d      = issue(d, hit[5:0]);
                    d.snap = sif.sel;
                    d.st   = SEQ_WAIT;
                    d.busy = 1'b1;
                end
            end
            SEQ_WAIT: begin
                if (sif.result_ready[q.chan]) begin
                    if (q.chan != `LAST_CH) begin
                        hit = find_from(q.snap, 6'(q.chan + 6'h01));
                    end
                    if (hit[6]) begin
                        d = issue(d, hit[5:0]);
                    end else begin
                        d.st   = SEQ_IDLE;
                        d.busy = 1'b0;
                        d.done = 1'b1;
                    end
                end
            end
            default: begin
                d.st   = SEQ_IDLE;
                d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sif.busy     = q.busy;
    assign sif.done     = q.done;
    assign sif.conv_req = q.conv_req;
    assign sif.chan     = q.chan;
    assign sif.class3   = q.class3;
    assign sif.conv_id  = q.conv_id;
    assign sif.internal = q.internal;

    // Channel of the previous request in this scan, for order checking
    logic [6:0] last_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q <= 7'h00;
        end else if (q.st == SEQ_IDLE) begin
            last_q <= 7'h00;
        end else if (q.conv_req) begin
            last_q <= {1'b1, q.chan};
        end
    end

    // A function result cannot be part-selected, so it lands on a net first
    logic [6:0] first_hit;
    assign first_hit = find_from(q.snap, 6'h00);

    sequence s_go;
        (q.st == SEQ_IDLE) && sif.start && (sif.sel != '0);
    endsequence
    sequence s_first_req;
        q.conv_req && q.snap[q.chan] && (q.chan == first_hit[5:0]);
    endsequence

    property p_scan_starts;
        @(posedge pclk) disable iff (!presetn) s_go |=> s_first_req;
    endproperty
    a_scan_starts: assert property (p_scan_starts)
        else $error("scan did not start at lowest selected channel");

    property p_ascending;
        @(posedge pclk) disable iff (!presetn)
            (q.conv_req && last_q[6]) |-> (q.chan > last_q[5:0]) && q.snap[q.chan];
    endproperty
    a_ascending: assert property (p_ascending)
        else $error("scan order not ascending or channel not selected");

    property p_class3;
        @(posedge pclk) disable iff (!presetn)
            (q.conv_req && q.chan >= `CLASS3_FIRST && q.chan <= `CLASS3_LAST)
            |-> q.class3 && (q.conv_id == `SHARED_CONV);
    endproperty
    a_class3: assert property (p_class3)
        else $error("class 3 channel not routed to shared converter");

    property p_internal;
        @(posedge pclk) disable iff (!presetn)
            q.conv_req |-> (q.internal == (q.chan >= `INTERNAL_FIRST));
    endproperty
    a_internal: assert property (p_internal)
        else $error("internal source flag wrong");
endmodule

// ===== hdl/adc_irq_scan_ctl.sv
`include "adc_ctl_regs.svh"

module adc_irq_scan_ctl
    import adc_ctl_pkg::*;
(
    input  wire logic        pclk,          // Bus clock, 100 MHz
    input  wire logic        presetn,       // Async reset, low
    input  wire logic [7:0]  paddr,         // APB address
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB enable
    input  wire logic        pwrite,        // APB direction
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error
    input  wire logic [53:0] result_ready,  // Result stored, per channel
    input  wire logic [53:0] data_read,     // Data register read, per channel
    input  wire logic        scan_trigger,  // Scan trigger pulse
    output logic             adc_irq,       // Converter request level
    output logic             irq,           // Masked event interrupt
    output logic             scan_conv_req, // Convert pulse for scan_chan
    output logic      [5:0]  scan_chan,     // Channel being scanned
    output logic             scan_class3,   // Channel is class 3
    output logic      [2:0]  scan_conv_id,  // Converter instance
    output logic             scan_internal, // Internal source selected
    output logic             scan_busy      // Scan in progress
);
    top_state_s q;
    top_state_s d;
    scan_if     sif ();

    // Two sparse registers into one channel-indexed vector
    function automatic chan_vec_t to_vec(logic [31:0] lo, logic [31:0] hi);
        chan_vec_t v;
        v                          = '0;
        v[`LOW_BITS-1:0]           = lo[`LOW_BITS-1:0];
        v[53:`HIGH_BASE]           = hi[53-`HIGH_BASE:0];
        return v;
    endfunction

    chan_vec_t ien_vec;
    chan_vec_t css_vec;
    chan_vec_t ien_vec_d;
    logic      setup;
    logic      wr;
    logic      mapped;
    logic      conv_evt;
    logic [1:0] w1c;

    assign ien_vec = to_vec(q.ien_lo, q.ien_hi);
    assign css_vec = to_vec(q.css_lo, q.css_hi);
    assign setup   = psel && !penable;
    // Writes land on the access edge where ready is seen high
    assign wr      = psel && penable && q.pready && pwrite;

    always_comb begin
        d         = q;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        d.start   = 1'b0;
        w1c       = 2'h0;
        mapped    = 1'b1;

        // Answer prepared in setup so the access phase ends in one cycle
        if (setup) begin
            d.pready = 1'b1;
            case (paddr)
                `OFS_IEN_LOW:  d.prdata = q.ien_lo;
                `OFS_IEN_HIGH: d.prdata = q.ien_hi;
                `OFS_CSS_LOW:  d.prdata = q.css_lo;
                `OFS_CSS_HIGH: d.prdata = q.css_hi;
                `OFS_RDY_LOW:  d.prdata = {4'h0, q.rdy[`LOW_BITS-1:0]};
                `OFS_RDY_HIGH: d.prdata = {10'h000, q.rdy[53:`HIGH_BASE]};
                `OFS_INT_STS:  d.prdata = {30'h0, q.int_sts};
                `OFS_INT_MASK: d.prdata = {30'h0, q.int_mask};
                `OFS_SCAN_CTL: begin
                    d.prdata = `RST_WORD;
                    d.prdata[`SCAN_GO] = sif.busy;
                    d.prdata[`SCAN_CH_MSB:`SCAN_CH_LSB] = sif.chan;
                end
                default: begin
                    d.prdata = `RST_WORD;
                    mapped   = 1'b0;
                end
            endcase
            d.pslverr = !mapped;
            if (pwrite) begin
                d.prdata = `RST_WORD;
            end
        end

        if (wr) begin
            case (paddr)
                `OFS_IEN_LOW:  d.ien_lo   = pwdata & `MASK_LOW;
                `OFS_IEN_HIGH: d.ien_hi   = pwdata & `MASK_IEN_HIGH;
                `OFS_CSS_LOW:  d.css_lo   = pwdata & `MASK_LOW;
                `OFS_CSS_HIGH: d.css_hi   = pwdata & `MASK_CSS_HIGH;
                `OFS_INT_STS:  w1c        = pwdata[1:0] & `MASK_INT;
                `OFS_INT_MASK: d.int_mask = pwdata[1:0] & `MASK_INT;
                `OFS_SCAN_CTL: d.start    = pwdata[`SCAN_GO];
                default: ;
            endcase
        end

        // Trigger and software start merge; a start while busy is dropped
        d.start = d.start || scan_trigger;

        // A new result wins over a read in the same cycle
        d.rdy = (q.rdy & ~data_read) | result_ready;

        ien_vec_d = to_vec(d.ien_lo, d.ien_hi);
        d.adc_irq = |(d.rdy & ien_vec_d);

        conv_evt = |(result_ready & ien_vec);
        d.int_sts = q.int_sts & ~w1c;
        d.int_sts[`EVT_CONV] = d.int_sts[`EVT_CONV] | conv_evt;
        d.int_sts[`EVT_SCAN] = d.int_sts[`EVT_SCAN] | sif.done;
        d.irq = |(d.int_sts & d.int_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sif.sel          = css_vec;
    assign sif.start        = q.start;
    assign sif.result_ready = result_ready;

    scan_sequencer u_seq (
        .pclk    (pclk),
        .presetn (presetn),
        .sif     (sif)
    );

    assign prdata        = q.prdata;
    assign pready        = q.pready;
    assign pslverr       = q.pslverr;
    assign adc_irq       = q.adc_irq;
    assign irq           = q.irq;
    assign scan_conv_req = sif.conv_req;
    assign scan_chan     = sif.chan;
    assign scan_class3   = sif.class3;
    assign scan_conv_id  = sif.conv_id;
    assign scan_internal = sif.internal;
    assign scan_busy     = sif.busy;

    // Helpers read only by the checks below
    chan_vec_t clr_only;
    assign clr_only = data_read & ~result_ready;

    sequence s_wr_ien_lo;
        psel && penable && pready && pwrite && (paddr == `OFS_IEN_LOW);
    endsequence

    property p_irq_enabled;
        @(posedge pclk) disable iff (!presetn)
            (|(result_ready & ien_vec)) |=> adc_irq;
    endproperty
    a_irq_enabled: assert property (p_irq_enabled)
        else $error("enabled ready input raised no request");

    property p_irq_cause;
        @(posedge pclk) disable iff (!presetn)
            adc_irq |-> (|(q.rdy & ien_vec));
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("request without enabled ready flag");

    property p_unimpl_zero;
        @(posedge pclk) disable iff (!presetn)
            ((q.ien_lo & ~`MASK_LOW) == '0) && ((q.ien_hi & ~`MASK_IEN_HIGH) == '0)
            && ((q.css_lo & ~`MASK_LOW) == '0) && ((q.css_hi & ~`MASK_CSS_HIGH) == '0);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented bit holds one");

    property p_write_lands;
        @(posedge pclk) disable iff (!presetn)
            s_wr_ien_lo |=> (q.ien_lo == ($past(pwdata) & `MASK_LOW));
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("enable write not stored");

    property p_ready_clear;
        @(posedge pclk) disable iff (!presetn)
            (clr_only != '0) |=> ((q.rdy & $past(clr_only)) == '0);
    endproperty
    a_ready_clear: assert property (p_ready_clear)
        else $error("ready flag survived a read");

    property p_ready_set;
        @(posedge pclk) disable iff (!presetn)
            (result_ready != '0) |=> ((q.rdy & $past(result_ready)) == $past(result_ready));
    endproperty
    a_ready_set: assert property (p_ready_set)
        else $error("result did not set ready flag");

    property p_css_hi_layout;
        @(posedge pclk) disable iff (!presetn)
            (psel && penable && pready && pwrite && (paddr == `OFS_CSS_HIGH))
            |=> !q.css_hi[19] && (q.css_hi[21:20] == $past(pwdata[21:20]));
    endproperty
    a_css_hi_layout: assert property (p_css_hi_layout)
        else $error("scan high layout wrong");

    property p_ready_one;
        @(posedge pclk) disable iff (!presetn)
            setup |=> pready ##1 !pready;
    endproperty
    a_ready_one: assert property (p_ready_one)
        else $error("ready not a single cycle after setup");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
            (setup && !mapped) |=> pslverr && (prdata == '0);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");

    property p_mapped_ok;
        @(posedge pclk) disable iff (!presetn)
            (setup && mapped) |=> !pslverr;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok)
        else $error("mapped access flagged as error");

    property p_rd_ien_hi;
        @(posedge pclk) disable iff (!presetn)
            (setup && !pwrite && (paddr == `OFS_IEN_HIGH)) |=> (prdata == $past(q.ien_hi));
    endproperty
    a_rd_ien_hi: assert property (p_rd_ien_hi)
        else $error("high enable read wrong");

    property p_rd_css_hi;
        @(posedge pclk) disable iff (!presetn)
            (setup && !pwrite && (paddr == `OFS_CSS_HIGH)) |=> ((prdata & ~`MASK_CSS_HIGH) == '0);
    endproperty
    a_rd_css_hi: assert property (p_rd_css_hi)
        else $error("unimplemented scan bit read as one");

    property p_wr_ien_hi;
        @(posedge pclk) disable iff (!presetn)
            (wr && (paddr == `OFS_IEN_HIGH)) |=> (q.ien_hi == ($past(pwdata) & `MASK_IEN_HIGH));
    endproperty
    a_wr_ien_hi: assert property (p_wr_ien_hi)
        else $error("high enable write not stored");

    property p_wr_css_lo;
        @(posedge pclk) disable iff (!presetn)
            (wr && (paddr == `OFS_CSS_LOW))
            |=> (css_vec[`LOW_BITS-1:0] == $past(pwdata[`LOW_BITS-1:0]));
    endproperty
    a_wr_css_lo: assert property (p_wr_css_lo)
        else $error("low scan write not stored");

    property p_no_irq_disabled;
        @(posedge pclk) disable iff (!presetn)
            ((ien_vec == '0) && !wr) |=> !adc_irq;
    endproperty
    a_no_irq_disabled: assert property (p_no_irq_disabled)
        else $error("request with every input disabled");

    property p_conv_sts;
        @(posedge pclk) disable iff (!presetn)
            conv_evt |=> q.int_sts[`EVT_CONV];
    endproperty
    a_conv_sts: assert property (p_conv_sts)
        else $error("enabled result did not set status");

    property p_conv_irq;
        @(posedge pclk) disable iff (!presetn)
            (conv_evt && q.int_mask[`EVT_CONV] && !wr) |=> irq;
    endproperty
    a_conv_irq: assert property (p_conv_irq)
        else $error("unmasked result raised no interrupt");

    property p_w1c;
        @(posedge pclk) disable iff (!presetn)
            (wr && (paddr == `OFS_INT_STS) && pwdata[`EVT_CONV] && !conv_evt)
            |=> !q.int_sts[`EVT_CONV];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("status bit survived write of one");

    property p_scan_sts;
        @(posedge pclk) disable iff (!presetn)
            sif.done |=> q.int_sts[`EVT_SCAN];
    endproperty
    a_scan_sts: assert property (p_scan_sts)
        else $error("scan end did not set status");

    property p_start_trig;
        @(posedge pclk) disable iff (!presetn)
            scan_trigger |=> q.start;
    endproperty
    a_start_trig: assert property (p_start_trig)
        else $error("scan trigger not taken");

    property p_req_busy;
        @(posedge pclk) disable iff (!presetn)
            scan_conv_req |-> scan_busy;
    endproperty
    a_req_busy: assert property (p_req_busy)
        else $error("scan request outside a scan");
endmodule

// ===== sim/adc_irq_scan_ctl_tb.sv
`include "adc_ctl_regs.svh"

module adc_irq_scan_ctl_tb
    import adc_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk;
    logic        presetn;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    chan_vec_t   result_ready;
    chan_vec_t   data_read;
    logic        scan_trigger;
    logic        adc_irq;
    logic        irq;
    logic        scan_conv_req;
    logic [5:0]  scan_chan;
    logic        scan_class3;
    logic [2:0]  scan_conv_id;
    logic        scan_internal;
    logic        scan_busy;
    logic [31:0] rd;
    logic        er;
    int          err_count;
    int          tests_run;

    adc_irq_scan_ctl dut_u (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .result_ready, .data_read, .scan_trigger, .adc_irq, .irq, .scan_conv_req,
        .scan_chan, .scan_class3, .scan_conv_id, .scan_internal, .scan_busy
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Request held until pready seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            chk("apb pready", 32'h0, 32'h1);
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        #1;
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    // One-cycle pulse on a result or data-read line
    task automatic pulse(input logic is_read, input int ch);
        @(posedge pclk);
        if (is_read) data_read[ch] <= 1'b1;
        else result_ready[ch] <= 1'b1;
        @(posedge pclk);
        data_read    <= '0;
        result_ready <= '0;
        #1;
    endtask

    task automatic trigger();
        @(posedge pclk);
        scan_trigger <= 1'b1;
        @(posedge pclk);
        scan_trigger <= 1'b0;
    endtask

    task automatic t_reset();
        rdchk("ien_low rst", `OFS_IEN_LOW, 32'h0);
        rdchk("ien_high rst", `OFS_IEN_HIGH, 32'h0);
        rdchk("css_low rst", `OFS_CSS_LOW, 32'h0);
        rdchk("css_high rst", `OFS_CSS_HIGH, 32'h0);
        chk("adc_irq rst", {31'h0, adc_irq}, 32'h0);
    endtask

    task automatic t_rw();
        logic [7:0]  adr [4];
        logic [31:0] msk [4];
        adr = '{`OFS_IEN_LOW, `OFS_IEN_HIGH, `OFS_CSS_LOW, `OFS_CSS_HIGH};
        msk = '{32'h0fff_ffff, 32'h003f_e3fe, 32'h0fff_ffff, 32'h0037_e3fe};
        for (int k = 0; k < 4; k++) begin
            wr(adr[k], 32'hffff_ffff);
            rdchk("ones readback", adr[k], msk[k]);
            wr(adr[k], 32'h0);
            rdchk("zero readback", adr[k], 32'h0);
        end
        wr(8'h24, 32'hffff_ffff);
        chk("unmapped err", {31'h0, er}, 32'h1);
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped data", rd, 32'h0);
    endtask

    task automatic t_irq();
        wr(`OFS_IEN_LOW, 32'h0000_0008);
        wr(`OFS_IEN_HIGH, 32'h0020_0000);
        wr(`OFS_INT_MASK, 32'h1);
        wr(`OFS_INT_STS, 32'h3);
        pulse(1'b0, 4);
        chk("disabled ch irq", {31'h0, adc_irq}, 32'h0);
        rdchk("ready ch4 set", `OFS_RDY_LOW, 32'h0000_0010);
        rdchk("no event sts", `OFS_INT_STS, 32'h0);
        pulse(1'b1, 4);
        rdchk("ready ch4 clr", `OFS_RDY_LOW, 32'h0);
        pulse(1'b0, 3);
        chk("enabled ch irq", {31'h0, adc_irq}, 32'h1);
        chk("masked-in irq", {31'h0, irq}, 32'h1);
        pulse(1'b1, 3);
        chk("irq after read", {31'h0, adc_irq}, 32'h0);
        wr(`OFS_INT_STS, 32'h1);
        chk("irq after w1c", {31'h0, irq}, 32'h0);
        pulse(1'b0, 53);
        chk("ch53 irq", {31'h0, adc_irq}, 32'h1);
        rdchk("ready ch53", `OFS_RDY_HIGH, 32'h0020_0000);
        pulse(1'b1, 53);
        wr(`OFS_INT_STS, 32'h1);
        wr(`OFS_INT_MASK, 32'h0);
        pulse(1'b0, 3);
        chk("masked-out irq", {31'h0, irq}, 32'h0);
        rdchk("sts masked-out", `OFS_INT_STS, 32'h1);
        pulse(1'b1, 3);
        wr(`OFS_INT_STS, 32'h1);
    endtask

    task automatic wait_req();
        int i;
        for (i = 0; i < 20; i++) begin
            #1;
            if (scan_conv_req === 1'b1) break;
            @(posedge pclk);
        end
        if (i == 20) begin
            chk("scan request", 32'h0, 32'h1);
            wrap_up();
        end
    endtask

    task automatic t_scan();
        int          i;
        logic [5:0]  ch [3];
        logic [2:0]  cid [3];
        logic [2:0]  c3 [3];
        logic [2:0]  inr [3];
        ch  = '{6'h02, 6'h07, 6'h32};
        cid = '{3'h2, 3'h7, 3'h2};
        c3  = '{3'h0, 3'h1, 3'h0};
        inr = '{3'h0, 3'h0, 3'h1};
        wr(`OFS_IEN_LOW, 32'h0);
        wr(`OFS_IEN_HIGH, 32'h0);
        wr(`OFS_INT_MASK, 32'h2);
        trigger();
        repeat (5) @(posedge pclk);
        #1;
        chk("empty scan busy", {31'h0, scan_busy}, 32'h0);
        wr(`OFS_CSS_LOW, 32'h0000_0084);
        wr(`OFS_CSS_HIGH, 32'h0004_0000);
        // First round from the trigger pulse, second from a register start
        for (int r = 0; r < 2; r++) begin
            if (r == 0) begin
                trigger();  // Scanned inputs see only the scan trigger
            end else begin
                wr(`OFS_SCAN_CTL, 32'h1);
            end
            for (int k = 0; k < 3; k++) begin
                wait_req();
                chk("scan chan", {26'h0, scan_chan}, {26'h0, ch[k]});
                chk("scan class3", {31'h0, scan_class3}, {29'h0, c3[k]});
                chk("scan conv id", {29'h0, scan_conv_id}, {29'h0, cid[k]});
                chk("scan internal", {31'h0, scan_internal}, {29'h0, inr[k]});
                chk("scan busy", {31'h0, scan_busy}, 32'h1);
                if (k == 0) begin
                    rdchk("scan status", `OFS_SCAN_CTL, {18'h0, ch[0], 8'h01});
                end
                pulse(1'b0, int'(ch[k]));
            end
            for (i = 0; i < 20; i++) begin
                if (scan_busy === 1'b0) break;
                @(posedge pclk);
                #1;
            end
            chk("scan end", {31'h0, scan_busy}, 32'h0);
            if (i == 20) begin
                wrap_up();
            end
            repeat (2) @(posedge pclk);
            #1;
            chk("scan done irq", {31'h0, irq}, 32'h1);
            rdchk("scan done sts", `OFS_INT_STS, 32'h2);
            wr(`OFS_INT_STS, 32'h2);
        end
    endtask

    initial begin
        err_count    = 0;
        tests_run    = 0;
        presetn      = 1'b0;
        paddr        = 8'h0;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        pwdata       = 32'h0;
        result_ready = '0;
        data_read    = '0;
        scan_trigger = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rw();
        t_irq();
        t_scan();
        wrap_up();
    end
endmodule
